// ---- hw/hsw_params.svh ----
// Offsets, field positions and reset values of the high-speed write port.
`ifndef HSW_PARAMS_SVH
`define HSW_PARAMS_SVH

// ****************************************************************
// Bus side register map (byte addresses)
// ****************************************************************
`define HSW_OFS_CONFIG 5'h00
`define HSW_OFS_CTRL 5'h04
`define HSW_OFS_SAMPLE 5'h08
`define HSW_OFS_PWRDN 5'h0c
`define HSW_OFS_STATUS 5'h10

`define HSW_CONFIG_RESET 1'h1
`define HSW_CFG_ENABLE_BIT 0
`define HSW_STAT_ADDRESSED_BIT 0
`define HSW_STAT_COUNT_LSB 8

// ****************************************************************
// Serial byte layout
// ****************************************************************
`define HSW_ADDR_PREFIX 5'h13
`define HSW_BITS_PER_BYTE 4'h8
`define HSW_CTRL_PD_BIT 0
`define HSW_PD_ONE_BIT 7
`define HSW_PD_TWO_BIT 6

`endif

// ---- hw/hsw_pkg.sv ----
// Types shared by the high-speed write port.
package hsw_pkg;

   // ****************************************************************
   // Bit-level line state
   // ****************************************************************
   typedef enum logic [2:0] {
      HSW_ST_IDLE = 3'b001,
      HSW_ST_RX = 3'b010,
      HSW_ST_ACK = 3'b100
   } hsw_state_t;

   // ****************************************************************
   // Meaning of the byte being received
   // ****************************************************************
   typedef enum logic [6:0] {
      HSW_PH_ADDR = 7'b0000001,
      HSW_PH_CTRL = 7'b0000010,
      HSW_PH_HIGH = 7'b0000100,
      HSW_PH_LOW = 7'b0001000,
      HSW_PH_PDHI = 7'b0010000,
      HSW_PH_PDLO = 7'b0100000,
      HSW_PH_DONE = 7'b1000000
   } hsw_phase_t;

endpackage : hsw_pkg

// ---- hw/hsw_write_port.sv ----
// Two-wire slave receiver for the high-speed write sequence of a quad DAC.
//
// Notes on behaviour
// - Master code byte is never acknowledged.
// - Matching write address after start is acknowledged.
// - Control byte bit 0 picks data or power-down.
// - First data byte holds sample bits eleven..four.
// - Second byte upper nibble, low nibble ignored.
// - Power-down first byte: bits seven and six.
// - Power-down second byte acknowledged, then sequence ends.
// - Data pairs repeat until stop or restart.
// - Repeated start returns to address phase.
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`include "hsw_params.svh"

module hsw_write_port #(
   parameter int SAMPLE_W = 12,
   parameter int COUNT_W = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic addr_pin_sel_hi,
   input wire logic addr_pin_sel_lo,
   output logic [7:0] ctrl_byte,
   output logic [SAMPLE_W-1:0] sample_word,
   output logic word_strobe,
   output logic powerdown_mode_bit_one,
   output logic powerdown_mode_bit_two,
   output logic pd_strobe,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   // ****************************************************************
   // Serial line state
   // ****************************************************************
   hsw_pkg::hsw_state_t state_reg, state_next;
   hsw_pkg::hsw_phase_t phase_reg, phase_next;
   logic scl_prev_reg, sda_prev_reg;
   logic [7:0] shift_reg, shift_next;
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic ack_reg, ack_next;
   logic [7:0] ctrl_reg, ctrl_next;
   logic [7:0] high_reg, high_next;
   logic [SAMPLE_W-1:0] sample_reg, sample_next;
   logic pd_one_reg, pd_one_next;
   logic pd_two_reg, pd_two_next;
   logic word_stb_reg, word_stb_next;
   logic pd_stb_reg, pd_stb_next;
   logic [COUNT_W-1:0] count_reg, count_next;
   logic enable_reg, enable_next;

   logic start_cond, stop_cond, scl_rise, scl_fall;
   logic addr_match;

   // Both edges of SDA must be seen with SCL high on two samples, so a data change
   // while SCL is high is a start or a stop and never a data bit.
   assign start_cond = scl_i & scl_prev_reg & sda_prev_reg & ~sda_i;
   assign stop_cond = scl_i & scl_prev_reg & ~sda_prev_reg & sda_i;
   assign scl_rise = ~scl_prev_reg & scl_i;
   assign scl_fall = scl_prev_reg & ~scl_i;
   assign addr_match = (shift_reg[7:3] == `HSW_ADDR_PREFIX) &&
                       (shift_reg[2] == addr_pin_sel_hi) &&
                       (shift_reg[1] == addr_pin_sel_lo) &&
                       ~shift_reg[0];

   always_comb begin
      state_next = state_reg;
      phase_next = phase_reg;
      shift_next = shift_reg;
      bit_cnt_next = bit_cnt_reg;
      ack_next = ack_reg;
      ctrl_next = ctrl_reg;
      high_next = high_reg;
      sample_next = sample_reg;
      pd_one_next = pd_one_reg;
      pd_two_next = pd_two_reg;
      word_stb_next = 1'b0;
      pd_stb_next = 1'b0;
      count_next = count_reg;
      if (start_cond) begin
         // A restart aborts any byte in flight and expects an address.
         state_next = hsw_pkg::HSW_ST_RX;
         phase_next = hsw_pkg::HSW_PH_ADDR;
         bit_cnt_next = 4'h0;
         ack_next = 1'b0;
      end else if (stop_cond) begin
         state_next = hsw_pkg::HSW_ST_IDLE;
         ack_next = 1'b0;
      end else begin
         unique case (state_reg)
            hsw_pkg::HSW_ST_IDLE: begin
            end
            hsw_pkg::HSW_ST_RX: begin
               if (scl_rise && bit_cnt_reg != `HSW_BITS_PER_BYTE) begin
                  shift_next = {shift_reg[6:0], sda_i};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end else if (scl_fall &&
                            bit_cnt_reg == `HSW_BITS_PER_BYTE) begin
                  state_next = hsw_pkg::HSW_ST_ACK;
                  ack_next = 1'b1;
                  unique case (phase_reg)
                     hsw_pkg::HSW_PH_ADDR: begin
                        // The master code never matches the address prefix.
                        ack_next = addr_match & enable_reg;
                     end
                     hsw_pkg::HSW_PH_CTRL: begin
                        ctrl_next = shift_reg;
                     end
                     hsw_pkg::HSW_PH_HIGH: begin
                        high_next = shift_reg;
                     end
                     hsw_pkg::HSW_PH_LOW: begin
                        // The low nibble of this byte carries nothing.
                        sample_next = SAMPLE_W'({high_reg, shift_reg[7:4]});
                        word_stb_next = 1'b1;
                        count_next = count_reg + COUNT_W'(1);
                     end
                     hsw_pkg::HSW_PH_PDHI: begin
                        high_next = shift_reg;
                     end
                     hsw_pkg::HSW_PH_PDLO: begin
                        pd_one_next = high_reg[`HSW_PD_ONE_BIT];
                        pd_two_next = high_reg[`HSW_PD_TWO_BIT];
                        pd_stb_next = 1'b1;
                     end
                     hsw_pkg::HSW_PH_DONE: begin
                        ack_next = 1'b0;
                     end
                  endcase
               end
            end
            hsw_pkg::HSW_ST_ACK: begin
               if (scl_fall) begin
                  ack_next = 1'b0;
                  bit_cnt_next = 4'h0;
                  state_next = ack_reg ? hsw_pkg::HSW_ST_RX
                                       : hsw_pkg::HSW_ST_IDLE;
                  unique case (phase_reg)
                     hsw_pkg::HSW_PH_ADDR:
                        phase_next = hsw_pkg::HSW_PH_CTRL;
                     hsw_pkg::HSW_PH_CTRL:
                        phase_next = ctrl_reg[`HSW_CTRL_PD_BIT] ?
                                     hsw_pkg::HSW_PH_PDHI :
                                     hsw_pkg::HSW_PH_HIGH;
                     hsw_pkg::HSW_PH_HIGH:
                        phase_next = hsw_pkg::HSW_PH_LOW;
                     hsw_pkg::HSW_PH_LOW:
                        phase_next = hsw_pkg::HSW_PH_HIGH;
                     hsw_pkg::HSW_PH_PDHI:
                        phase_next = hsw_pkg::HSW_PH_PDLO;
                     hsw_pkg::HSW_PH_PDLO,
                     hsw_pkg::HSW_PH_DONE:
                        phase_next = hsw_pkg::HSW_PH_DONE;
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= hsw_pkg::HSW_ST_IDLE;
         phase_reg <= hsw_pkg::HSW_PH_ADDR;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
         shift_reg <= 8'h00;
         bit_cnt_reg <= 4'h0;
         ack_reg <= 1'b0;
         ctrl_reg <= 8'h00;
         high_reg <= 8'h00;
         sample_reg <= '0;
         pd_one_reg <= 1'b0;
         pd_two_reg <= 1'b0;
         word_stb_reg <= 1'b0;
         pd_stb_reg <= 1'b0;
         count_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         scl_prev_reg <= scl_i;
         sda_prev_reg <= sda_i;
         shift_reg <= shift_next;
         bit_cnt_reg <= bit_cnt_next;
         ack_reg <= ack_next;
         ctrl_reg <= ctrl_next;
         high_reg <= high_next;
         sample_reg <= sample_next;
         pd_one_reg <= pd_one_next;
         pd_two_reg <= pd_two_next;
         word_stb_reg <= word_stb_next;
         pd_stb_reg <= pd_stb_next;
         count_reg <= count_next;
      end
   end

   // The line is open drain: only ever pulled low, released otherwise.
   assign sda_o = 1'b0;
   assign sda_oe = ack_reg;
   assign ctrl_byte = ctrl_reg;
   assign sample_word = sample_reg;
   assign word_strobe = word_stb_reg;
   assign powerdown_mode_bit_one = pd_one_reg;
   assign powerdown_mode_bit_two = pd_two_reg;
   assign pd_strobe = pd_stb_reg;

   // ****************************************************************
   // Register bus slave
   // ****************************************************************
   logic bus_done_reg, bus_done_next;
   logic [31:0] rdata_reg, rdata_next;

   // Every request waits exactly one cycle with ce high, so read data can be a flop.
   assign avs_waitrequest = (avs_read | avs_write) & ~bus_done_reg;
   assign avs_readdata = rdata_reg;

   always_comb begin
      bus_done_next = 1'b0;
      rdata_next = rdata_reg;
      enable_next = enable_reg;
      if ((avs_read | avs_write) && !bus_done_reg) begin
         bus_done_next = 1'b1;
         rdata_next = 32'h00000000;
         if (!avs_write) begin
            unique case (avs_address)
               `HSW_OFS_CONFIG:
                  rdata_next[`HSW_CFG_ENABLE_BIT] = enable_reg;
               `HSW_OFS_CTRL:
                  rdata_next[7:0] = ctrl_reg;
               `HSW_OFS_SAMPLE:
                  rdata_next[SAMPLE_W-1:0] = sample_reg;
               `HSW_OFS_PWRDN:
                  rdata_next[1:0] = {pd_one_reg, pd_two_reg};
               `HSW_OFS_STATUS: begin
                  rdata_next[`HSW_STAT_ADDRESSED_BIT] =
                     (phase_reg != hsw_pkg::HSW_PH_ADDR) &&
                     (state_reg != hsw_pkg::HSW_ST_IDLE);
                  rdata_next[`HSW_STAT_COUNT_LSB +: COUNT_W] = count_reg;
               end
               default:
                  rdata_next = 32'h00000000;
            endcase
         end
      end
      // A write lands only at the edge that completes the transfer, so a
      // request stalled by waitrequest never changes state early.
      if (avs_write && bus_done_reg &&
          avs_address == `HSW_OFS_CONFIG) begin
         enable_next = avs_writedata[`HSW_CFG_ENABLE_BIT];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bus_done_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         enable_reg <= `HSW_CONFIG_RESET;
      end else if (ce) begin
         bus_done_reg <= bus_done_next;
         rdata_reg <= rdata_next;
         enable_reg <= enable_next;
      end
   end

endmodule : hsw_write_port

// ---- sim/hsw_write_port_assertions.sv ----
// Port-level checks of the high-speed write port.
`timescale 1ns/100ps
module hsw_write_port_assertions (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic word_strobe,
   input wire logic pd_strobe,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_sda_only_low: assert property (sda_o == 1'b0)
      else $error("data line driven high");
   a_wait_one: assert property ($rose(avs_read | avs_write) && ce |->
      avs_waitrequest ##1 !avs_waitrequest) else $error("bad wait state");
   a_wait_idle: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
      else $error("waitrequest without request");
   a_ack_edge: assert property ($changed(sda_oe) |-> !$past(scl_i))
      else $error("ack changed while clock high");
   a_ack_hold: assert property (sda_oe && scl_i |=> sda_oe)
      else $error("ack dropped while clock high");
   a_ack_bound: assert property ($rose(sda_oe) |-> ##[1:1000] !sda_oe)
      else $error("ack held too long");
   a_word_ack: assert property (
      word_strobe |-> $rose(sda_oe) ##1 !word_strobe)
      else $error("word strobe not paired with ack");
   a_pd_ack: assert property (
      pd_strobe |-> $rose(sda_oe) ##1 !pd_strobe)
      else $error("power-down strobe not paired with ack");
   cover property (!ce && avs_waitrequest);
   cover property (word_strobe);
   cover property (pd_strobe);
   cover property ($fell(sda_oe));
endmodule : hsw_write_port_assertions
bind hsw_write_port hsw_write_port_assertions hsw_write_port_assertions_i (
   .mclk(mclk),
   .rst(rst),
   .ce(ce),
   .scl_i(scl_i),
   .sda_o(sda_o),
   .sda_oe(sda_oe),
   .word_strobe(word_strobe),
   .pd_strobe(pd_strobe),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest)
);

// ---- sim/hsw_master_model.sv ----
// Behavioural two-wire bus master driving the serial side of the port.
`timescale 1ns/100ps
module hsw_master_model (
   input wire logic mclk,
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   int hp = 2;
   logic sda_drv = 1'b1;
   // Open-drain wire with a pull-up, so a released line reads high.
   assign sda = sda_drv & ~sda_oe;
   initial scl = 1'b1;
   task automatic tick();
      repeat (hp) @(posedge mclk);
   endtask : tick
   // Also serves as repeated start when the clock is low.
   task automatic start();
      sda_drv <= 1'b1; tick(); scl <= 1'b1; tick();
      sda_drv <= 1'b0; tick(); scl <= 1'b0; tick();
   endtask : start
   task automatic stop();
      sda_drv <= 1'b0; tick(); scl <= 1'b1; tick(); sda_drv <= 1'b1; tick();
   endtask : stop
   task automatic put(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_drv <= b[i]; tick(); scl <= 1'b1; tick(); tick();
         scl <= 1'b0; tick();
      end
      sda_drv <= 1'b1; tick(); scl <= 1'b1; tick();
      @(negedge mclk);
      ack = ~sda;
      tick(); scl <= 1'b0; tick();
   endtask : put
endmodule : hsw_master_model

// ---- sim/hsw_write_port_tb.sv ----
// Self-checking bench for the high-speed write port.
`timescale 1ns/100ps
`include "hsw_params.svh"
module hsw_write_port_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic a_hi = 1'b0;
   logic a_lo = 1'b0;
   logic scl, sda, sda_o, sda_oe, ws, pds, pd1, pd2, ack;
   logic [7:0] ctrl;
   logic [11:0] smp, last;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic avs_waitrequest;
   int bad_count = 0, checked = 0, nws = 0, npd = 0;
   always #4 mclk = ~mclk;
   always @(posedge mclk) if (ws === 1'b1) nws <= nws + 1;
   always @(posedge mclk) if (pds === 1'b1) npd <= npd + 1;
   hsw_master_model hsw_master_model_i (.mclk(mclk), .sda_oe(sda_oe),
      .scl(scl), .sda(sda));
   hsw_write_port hsw_write_port_i (.mclk(mclk), .rst(rst), .ce(ce),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .addr_pin_sel_hi(a_hi), .addr_pin_sel_lo(a_lo), .ctrl_byte(ctrl),
      .sample_word(smp), .word_strobe(ws), .powerdown_mode_bit_one(pd1),
      .powerdown_mode_bit_two(pd2), .pd_strobe(pds),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   function automatic logic [7:0] adr(input logic rw);
      return {`HSW_ADDR_PREFIX, a_hi, a_lo, rw};
   endfunction : adr
   function automatic logic [11:0] expw(input logic [7:0] h, l);
      return {h, l[7:4]};
   endfunction : expw
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic end_sim();
      if (bad_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   // Holds the request until waitrequest is seen low, then idles a cycle.
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
      int n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0 && ++n < 50);
      if (n == 50) bad_count++;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask : bus
   task automatic tx(input logic [7:0] b, input logic e);
      hsw_master_model_i.put(b, ack);
      chk(ack, e);
   endtask : tx
   initial begin
      #400000;
      bad_count++;
      end_sim();
   end
   initial begin
      logic [7:0] h, l, c;
      void'($urandom(32'h61b4eca4));
      repeat (3) @(posedge mclk);
      {a_hi, a_lo} <= 2'($urandom);
      rst <= 1'b0;
      @(posedge mclk);
      bus(0, `HSW_OFS_CONFIG, 0); chk(q, `HSW_CONFIG_RESET);
      bus(0, 5'h14, 0); chk(q, 0);
      for (int k = 0; k < 2; k++) begin
         hsw_master_model_i.hp = 2 + 4 * k;
         hsw_master_model_i.start();
         tx({5'h01, 3'($urandom)}, 0);
         hsw_master_model_i.start();
         tx(adr(0), 1);
         c = {2'b00, 2'($urandom), 1'b0, 2'($urandom), 1'b0};
         tx(c, 1);
         repeat (3) begin
            h = 8'($urandom); l = 8'($urandom); last = expw(h, l);
            tx(h, 1); tx(l, 1);
            chk(smp, last);
         end
         chk(ctrl, c);
         tx(8'($urandom), 1);
         hsw_master_model_i.start();
         tx(adr(0), 1);
         c[0] = 1'b1;
         tx(c, 1);
         h = {2'($urandom), 6'h00};
         tx(h, 1); tx({4'h0, 4'($urandom)}, 1);
         chk({pd1, pd2}, h[7:6]);
         tx(8'($urandom), 0);
         hsw_master_model_i.stop();
         chk(nws, 3 * (k + 1));
         chk(npd, k + 1);
      end
      hsw_master_model_i.start();
      tx(adr(1), 0);
      hsw_master_model_i.start();
      tx(adr(0) ^ 8'h02, 0);
      hsw_master_model_i.stop();
      bus(1, `HSW_OFS_CONFIG, 0);
      bus(0, `HSW_OFS_CONFIG, 0);
      chk(q, 0);
      hsw_master_model_i.start();
      tx(adr(0), 0);
      hsw_master_model_i.stop();
      bus(1, `HSW_OFS_CONFIG, 1);
      // A low clock enable must hold the bus answer back.
      ce <= 1'b0;
      fork
         bus(0, `HSW_OFS_SAMPLE, 0);
         begin
            repeat (4) begin
               @(posedge mclk);
               chk(avs_waitrequest, 1);
            end
            ce <= 1'b1;
         end
      join
      chk(q, {20'h0, last});
      bus(0, `HSW_OFS_PWRDN, 0);
      chk(q, {30'h0, h[7:6]});
      bus(0, `HSW_OFS_CTRL, 0);
      chk(q, {24'h0, c});
      bus(0, `HSW_OFS_STATUS, 0);
      chk(q, 32'h6 << `HSW_STAT_COUNT_LSB);
      end_sim();
   end
endmodule : hsw_write_port_tb
